// ### hdl/power_mode_defs.svh
`ifndef POWER_MODE_DEFS_SVH
`define POWER_MODE_DEFS_SVH

// ****************************************************************
// Register indices; the bus byte address is four times the index
// ****************************************************************
`define IDX_SYSTEM_MODE_CONTROL 4'h5
`define IDX_INTERRUPT_MASK_SECOND 4'hF
`define IDX_BANK_SELECT 4'h3
`define IDX_MODE_STATUS 4'h8
`define IDX_FLAGS 4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_RX_ERROR 6
`define BIT_RX_FULL 5
`define BIT_TX_EMPTY 4
`define BIT_TIME_BASE 3
`define BIT_EXT_ONE 2
`define BIT_MAIN_TIMER 0
`define BIT_WAKE_EDGE_MODE 0
`define BIT_SLEEP_SELECT 1
`define MASK2_WRITABLE 8'h7D
`define SCR_WRITABLE 8'h73
`define BANK_LSB 6

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SCR 8'h04
`define RST_MASK2 8'h00
`define RST_BANK 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ 40
`define WARMUP_US 100
`define WARMUP_CYCLES (`WARMUP_US * `CLK_MHZ)

`endif

// ### hdl/power_mode_pkg.sv
package power_mode_pkg;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_IDLE = 4'b0010,
        MODE_SLEEP = 4'b0100,
        MODE_WARMUP = 4'b1000
    } mode_t;

endpackage : power_mode_pkg

// ### hdl/pin_sync.sv
`timescale 1ns/1ps

// Three stage synchroniser; output changes once stages two and three agree
module pin_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic level_out
);
    logic [2:0] stage_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_reg <= 3'h7;
        end else begin
            stage_reg <= {stage_reg[1:0], pin_in};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_out <= 1'b1;
        end else if (stage_reg[1] == stage_reg[2]) begin
            level_out <= stage_reg[2];
        end
    end
endmodule : pin_sync

// ### hdl/power_mode_wakeup_control.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "power_mode_defs.svh"

// Overview of operation
// R1: Mask bit 6 gates the receive error flag interrupt.
// R2: Mask bit 5 gates the receive buffer full flag interrupt.
// R3: Mask bit 4 gates the transmit buffer empty flag interrupt.
// R4: Mask bit 3 gates the time base timer flag interrupt.
// R5: Mask bit 2 gates the external input one flag interrupt.
// R6: Mask bit 0 gates the main timer overflow flag interrupt.
// R7: Interrupt reaches core only when masked in and global enable set; the code gates watchdog request and ext zero pin by global enable alone.
// R8: Sleep instruction with sleep select 1 enters sleep mode.
// R9: Sleep instruction with sleep select 0 enters idle mode.
// R10: Normal mode clocks core and peripherals.
// R11: Idle stops core, keeps oscillator and peripherals running.
// R12: Idle wakes on enabled interrupt, watchdog request or ext zero pin.
// R13: Idle wake with global enable vectors first, then resumes; the code pulses vector and resume in the same cycle.
// R14: Idle wake without global enable resumes directly, no vector.
// R15: Sleep stops oscillator, core and peripherals.
// R16: Sleep ends only on wake pin or reset; bit 0 picks edge or level.
// R17: After sleep wake, wait warm-up then resume.
// R18: Other party holds wake pin low before level-mode sleep.
// R19: Edge mode enters sleep even with wake pin high.
// R20: Reset pin low or watchdog timeout fully resets in every mode.
// R21: Flags that cannot wake still latch their request.
// R22: System control register reachable only in bank 0.
// R23: Pins synchronised; warm-up counted by dedicated counter.
module power_mode_wakeup_control
    import power_mode_pkg::*;
#(
    parameter int unsigned WARMUP_COUNT = `WARMUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_instruction,
    input wire logic global_irq_on_instruction,
    input wire logic global_irq_off_instruction,
    input wire logic irq_return_instruction,
    input wire logic irq_taken,
    input wire logic rx_error_flag,
    input wire logic rx_full_flag,
    input wire logic tx_empty_flag,
    input wire logic time_base_flag,
    input wire logic ext_one_flag,
    input wire logic main_timer_flag,
    input wire logic watchdog_irq,
    input wire logic watchdog_timeout,
    input wire logic ext_zero_pin_n,
    input wire logic sleep_wake_pin_n,
    input wire logic reset_pin_n,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic osc_en,
    output logic irq_to_core,
    output logic resume_pulse,
    output logic vector_pulse,
    output logic chip_reset
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic wake_pin_s;
    logic reset_pin_s;
    logic ext_zero_s;

    pin_sync u_wake_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_in(sleep_wake_pin_n),
        .level_out(wake_pin_s)
    ); // R23
    pin_sync u_reset_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_in(reset_pin_n),
        .level_out(reset_pin_s)
    ); // R23
    pin_sync u_ext0_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_in(ext_zero_pin_n),
        .level_out(ext_zero_s)
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] scr_reg;
    logic [7:0] mask2_reg;
    logic [7:0] bank_reg;
    logic global_en_reg;
    logic [7:0] flags_reg;
    mode_t mode_reg;
    logic [31:0] warm_cnt_reg;
    logic wake_prev_reg;
    logic soft_rst;

    // Reset pin low or watchdog timeout: registers, flags, global enable and mode back to reset state
    assign soft_rst = ~reset_pin_s | watchdog_timeout; // R20

    logic setup_ok;
    logic wr_en;
    logic [3:0] idx;
    logic addr_ok;
    logic bank0;

    assign idx = paddr[5:2];
    assign bank0 = (bank_reg[7:6] == 2'b00);
    assign addr_ok = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'b00);
    assign setup_ok = psel && penable && pready;
    assign wr_en = setup_ok && pwrite && addr_ok;

    // Single wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (!addr_ok) begin
                pslverr <= 1'b1;
            end else begin
                case (idx)
                    `IDX_SYSTEM_MODE_CONTROL: begin
                        if (bank0) begin
                            prdata <= {24'h0, scr_reg}; // R22
                        end else begin
                            pslverr <= 1'b1;
                        end
                    end
                    `IDX_INTERRUPT_MASK_SECOND: prdata <= {24'h0, mask2_reg};
                    `IDX_BANK_SELECT: prdata <= {24'h0, bank_reg};
                    `IDX_MODE_STATUS: prdata <= {24'h0, 3'h0, global_en_reg, mode_reg};
                    `IDX_FLAGS: prdata <= {24'h0, flags_reg};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scr_reg <= `RST_SCR;
            mask2_reg <= `RST_MASK2;
            bank_reg <= `RST_BANK;
        end else if (soft_rst) begin
            scr_reg <= `RST_SCR;
            mask2_reg <= `RST_MASK2;
            bank_reg <= `RST_BANK;
        end else if (wr_en) begin
            if (idx == `IDX_SYSTEM_MODE_CONTROL && bank0) begin
                scr_reg <= (pwdata[7:0] & `SCR_WRITABLE) | `RST_SCR; // R22
            end
            if (idx == `IDX_INTERRUPT_MASK_SECOND) begin
                mask2_reg <= pwdata[7:0] & `MASK2_WRITABLE;
            end
            if (idx == `IDX_BANK_SELECT) begin
                bank_reg <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Request flags: always recorded, set wins over software clear
    // ****************************************************************
    logic [7:0] flag_in;
    assign flag_in = {1'b0, rx_error_flag, rx_full_flag, tx_empty_flag,
        time_base_flag, ext_one_flag, 1'b0, main_timer_flag};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= 8'h00;
        end else if (soft_rst) begin
            flags_reg <= 8'h00;
        end else if (wr_en && idx == `IDX_FLAGS) begin
            flags_reg <= (flags_reg & ~pwdata[7:0]) | flag_in; // R21
        end else begin
            flags_reg <= flags_reg | flag_in; // R21
        end
    end

    logic [7:0] masked;
    logic any_enabled;
    always_comb begin
        masked = 8'h00;
        masked[`BIT_RX_ERROR] = flags_reg[`BIT_RX_ERROR] & mask2_reg[`BIT_RX_ERROR]; // R1
        masked[`BIT_RX_FULL] = flags_reg[`BIT_RX_FULL] & mask2_reg[`BIT_RX_FULL]; // R2
        masked[`BIT_TX_EMPTY] = flags_reg[`BIT_TX_EMPTY] & mask2_reg[`BIT_TX_EMPTY]; // R3
        masked[`BIT_TIME_BASE] = flags_reg[`BIT_TIME_BASE] & mask2_reg[`BIT_TIME_BASE]; // R4
        masked[`BIT_EXT_ONE] = flags_reg[`BIT_EXT_ONE] & mask2_reg[`BIT_EXT_ONE]; // R5
        masked[`BIT_MAIN_TIMER] = flags_reg[`BIT_MAIN_TIMER]
            & mask2_reg[`BIT_MAIN_TIMER]; // R6
    end
    assign any_enabled = |masked;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            global_en_reg <= 1'b0;
        end else if (soft_rst) begin
            global_en_reg <= 1'b0;
        end else if (global_irq_off_instruction || irq_taken) begin
            global_en_reg <= 1'b0; // R7
        end else if (global_irq_on_instruction || irq_return_instruction) begin
            global_en_reg <= 1'b1; // R7
        end
    end

    // ****************************************************************
    // Mode machine
    // ****************************************************************
    logic idle_wake;
    logic wake_edge;
    logic sleep_wake;

    assign idle_wake = any_enabled | watchdog_irq | ~ext_zero_s; // R12
    assign wake_edge = wake_prev_reg & ~wake_pin_s;
    // Level mode wakes on a high pin, so the pin must sit low before entry.
    // Edge mode needs a fresh falling edge, so a high pin does not block entry
    assign sleep_wake = scr_reg[`BIT_WAKE_EDGE_MODE] ? wake_edge : wake_pin_s; // R16 R19

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_prev_reg <= 1'b1;
        end else begin
            wake_prev_reg <= wake_pin_s;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= MODE_NORMAL;
            warm_cnt_reg <= 32'h0;
            resume_pulse <= 1'b0;
            vector_pulse <= 1'b0;
        end else if (soft_rst) begin
            mode_reg <= MODE_NORMAL; // R20
            warm_cnt_reg <= 32'h0;
            resume_pulse <= 1'b0;
            vector_pulse <= 1'b0;
        end else begin
            resume_pulse <= 1'b0;
            vector_pulse <= 1'b0;
            case (mode_reg)
                MODE_NORMAL: begin
                    if (sleep_instruction) begin
                        if (scr_reg[`BIT_SLEEP_SELECT]) begin
                            mode_reg <= MODE_SLEEP; // R8
                        end else begin
                            mode_reg <= MODE_IDLE; // R9
                        end
                    end
                end
                MODE_IDLE: begin
                    if (idle_wake) begin
                        mode_reg <= MODE_NORMAL;
                        resume_pulse <= 1'b1; // R14
                        vector_pulse <= global_en_reg; // R13
                    end
                end
                MODE_SLEEP: begin
                    if (sleep_wake) begin
                        mode_reg <= MODE_WARMUP; // R16
                        warm_cnt_reg <= 32'h0;
                    end
                end
                MODE_WARMUP: begin
                    if (warm_cnt_reg >= WARMUP_COUNT - 1) begin
                        mode_reg <= MODE_NORMAL; // R17
                        resume_pulse <= 1'b1;
                    end else begin
                        warm_cnt_reg <= warm_cnt_reg + 32'h1; // R23
                    end
                end
                default: mode_reg <= MODE_NORMAL;
            endcase
        end
    end

    // ****************************************************************
    // Clock gating enables and outputs
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_en <= 1'b1;
            irq_to_core <= 1'b0;
            chip_reset <= 1'b1;
        end else begin
            core_clk_en <= (mode_reg == MODE_NORMAL); // R10 R11 R15
            periph_clk_en <= (mode_reg == MODE_NORMAL) || (mode_reg == MODE_IDLE); // R11
            osc_en <= (mode_reg != MODE_SLEEP); // R15
            irq_to_core <= (any_enabled | watchdog_irq | ~ext_zero_s) & global_en_reg; // R7
            chip_reset <= soft_rst; // R20
        end
    end

endmodule : power_mode_wakeup_control

// ### testbench/power_mode_chk.sv
`timescale 1ns/1ps
// ****************
// Port-level checks
// ****************
module power_mode_chk #(
    parameter int unsigned WARMUP_COUNT = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic sleep_instruction,
    input wire logic watchdog_timeout,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic resume_pulse,
    input wire logic vector_pulse,
    input wire logic chip_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_normal_clocks: assert property (core_clk_en |-> periph_clk_en && osc_en)
        else $error("core runs without peripherals");
    a_idle_keeps_osc: assert property (!core_clk_en && periph_clk_en |-> osc_en)
        else $error("idle lost oscillator");
    a_sleep_stops_all: assert property (!osc_en |-> !core_clk_en && !periph_clk_en)
        else $error("sleep left clocks on");
    a_sleep_enter: assert property (sleep_instruction && core_clk_en && !chip_reset
        |-> ##[1:2] !core_clk_en) else $error("core kept running");
    a_sleep_hold: assert property ($fell(osc_en) |=> !osc_en [*3])
        else $error("sleep left too early");
    a_resume_core: assert property (resume_pulse |-> ##[0:2] core_clk_en)
        else $error("core not restarted");
    a_vector_resume: assert property (vector_pulse |-> resume_pulse)
        else $error("vector without resume");
    a_wdt_reset: assert property (watchdog_timeout |-> ##[1:2] chip_reset)
        else $error("timeout gave no reset");
    cover property (vector_pulse);
    cover property (resume_pulse && !vector_pulse);
    cover property ($fell(osc_en));
endmodule : power_mode_chk

bind power_mode_wakeup_control power_mode_chk #(.WARMUP_COUNT(WARMUP_COUNT)) chk_i (
    .sys_clk, .sys_rst, .psel, .penable, .pready, .sleep_instruction, .watchdog_timeout,
    .core_clk_en, .periph_clk_en, .osc_en, .resume_pulse, .vector_pulse, .chip_reset);

// ### testbench/pin_partner.sv
`timescale 1ns/1ps
// Pins idle high as if pulled up
module pin_partner (
    input wire logic sys_clk,
    input wire logic wake_low,
    input wire logic ext0_low,
    input wire logic rst_low,
    input wire logic level_hold,
    output logic sleep_wake_pin_n,
    output logic ext_zero_pin_n,
    output logic reset_pin_n
);
    initial begin
        sleep_wake_pin_n = 1'b1;
        ext_zero_pin_n = 1'b1;
        reset_pin_n = 1'b1;
    end
    always @(posedge sys_clk) begin
        sleep_wake_pin_n <= !(wake_low || level_hold);
        ext_zero_pin_n <= !ext0_low;
        reset_pin_n <= !rst_low;
    end
endmodule : pin_partner

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "power_mode_defs.svh"
module tb_top;
    import power_mode_pkg::*;
    localparam int WARM = 8;
    localparam logic [5:0] A_SCR = {`IDX_SYSTEM_MODE_CONTROL, 2'b00};
    localparam logic [5:0] A_MSK = {`IDX_INTERRUPT_MASK_SECOND, 2'b00};
    localparam logic [5:0] A_BNK = {`IDX_BANK_SELECT, 2'b00};
    localparam logic [5:0] A_FLG = {`IDX_FLAGS, 2'b00};
    localparam logic [5:0] A_STS = {`IDX_MODE_STATUS, 2'b00};
    logic sys_clk = 0;
    logic sys_rst = 1;
    logic [31:0] paddr, pwdata, prdata, rd, seed;
    logic psel, penable, pwrite, pready, pslverr, err, got, vec;
    logic sleep_i, gon, goff, gret, gtak, wdi, wdt, wake_low, ext0_low, rst_low, hold;
    logic [6:0] flg;
    logic swp_n, ext0_n, rstp_n, core_en, per_en, osc_en, irq, resume, vector, chip_reset;
    int miscompares = 0;
    int cmp_count = 0;
    int mask_m, n, g, b2;
    always #12.5 sys_clk = ~sys_clk;
    power_mode_wakeup_control #(.WARMUP_COUNT(WARM)) uut (.sys_clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instruction(sleep_i),
        .global_irq_on_instruction(gon), .global_irq_off_instruction(goff),
        .irq_return_instruction(gret), .irq_taken(gtak), .rx_error_flag(flg[6]),
        .rx_full_flag(flg[5]), .tx_empty_flag(flg[4]), .time_base_flag(flg[3]),
        .ext_one_flag(flg[2]), .main_timer_flag(flg[0]), .watchdog_irq(wdi),
        .watchdog_timeout(wdt), .ext_zero_pin_n(ext0_n), .sleep_wake_pin_n(swp_n),
        .reset_pin_n(rstp_n), .core_clk_en(core_en), .periph_clk_en(per_en), .osc_en,
        .irq_to_core(irq), .resume_pulse(resume), .vector_pulse(vector), .chip_reset);
    pin_partner partner (.sys_clk, .wake_low, .ext0_low, .rst_low, .level_hold(hold),
        .sleep_wake_pin_n(swp_n), .ext_zero_pin_n(ext0_n), .reset_pin_n(rstp_n));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    // Request held until pready seen high at an edge; one idle cycle after
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        pwrite <= w;
        paddr <= {26'h0, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        check(k, 2, "apb wait state");
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask : apb
    // Samples resume and vector at the edge where resume is seen
    task automatic wait_resume(input int lim);
        n = 0;
        got = 0;
        while (!got && n < lim) begin
            @(posedge sys_clk);
            n++;
            got = (resume === 1'b1);
            vec = vector;
        end
    endtask : wait_resume
    task automatic sleep_cmd();
        sleep_i <= 1;
        @(posedge sys_clk);
        sleep_i <= 0;
    endtask : sleep_cmd
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sleep_i, gon, goff, gret, gtak} = '0;
        {flg, wdi, wdt, wake_low, ext0_low, rst_low, hold} = '0;
        seed = 32'h5D43;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 0;
        repeat (2) @(posedge sys_clk);
        // ****************
        // Registers
        // ****************
        apb(0, A_SCR, 0);
        check(rd, `RST_SCR, "scr reset");
        apb(0, A_MSK, 0);
        check(rd, `RST_MASK2, "mask reset");
        repeat (4) begin
            seed = xs(seed);
            apb(1, A_MSK, seed);
            mask_m = seed[7:0] & 8'h7D;
            apb(0, A_MSK, 0);
            check(rd, mask_m, "mask rw");
        end
        apb(1, 6'h30, 32'hFF);
        check(err, 1, "unmapped");
        apb(1, A_BNK, 32'h40);
        apb(1, A_SCR, 32'h02);
        check(err, 1, "scr outside bank 0");
        apb(1, A_BNK, 0);
        apb(0, A_SCR, 0);
        check(rd, `RST_SCR, "scr kept");
        $display("register test done");
        // ****************
        // Idle wake per source: six flags, watchdog request, ext zero pin
        // ****************
        for (int b = 0; b < 9; b++) begin
            if (b == 1) continue;
            g = b % 2;
            b2 = (b == 0) ? 2 : 0;
            apb(1, A_MSK, (b < 7) ? (32'h1 << b) : 0);
            apb(1, A_SCR, 0);
            gon <= (g == 1);
            goff <= (g == 0);
            @(posedge sys_clk);
            {gon, goff} <= 2'b00;
            sleep_cmd();
            flg[b2] <= 1;
            repeat (6) @(posedge sys_clk);
            flg[b2] <= 0;
            check({core_en, per_en, osc_en}, 3'b011, "idle clocks");
            apb(0, A_STS, 0);
            check(rd[4:0], {g[0], 4'h2}, "idle status");
            apb(0, A_FLG, 0);
            check(rd[b2], 1, "blocked flag kept");
            if (b < 7) flg[b] <= 1;
            else if (b == 7) wdi <= 1;
            else ext0_low <= 1;
            wait_resume(30);
            check(got, 1, "idle wake");
            check(vec, g, "vector on wake");
            flg <= '0;
            {wdi, ext0_low} <= 2'b00;
            repeat (2) @(posedge sys_clk);
            if (b < 7) check(irq, g, "irq gate");
            gtak <= 1;
            @(posedge sys_clk);
            gtak <= 0;
            gret <= 1;
            @(posedge sys_clk);
            gret <= 0;
            apb(1, A_FLG, 32'h7D);
        end
        $display("idle test done");
        // ****************
        // Sleep: level wake, edge wake, reset from sleep
        // ****************
        hold <= 1;
        apb(1, A_SCR, 32'h02);
        repeat (5) @(posedge sys_clk);
        sleep_cmd();
        repeat (10) @(posedge sys_clk);
        check({core_en, per_en, osc_en}, 3'b000, "level sleep held");
        hold <= 0;
        wait_resume(40);
        check(got, 1, "level wake");
        apb(1, A_SCR, 32'h03);
        repeat (5) @(posedge sys_clk);
        sleep_cmd();
        repeat (20) @(posedge sys_clk);
        check({core_en, per_en, osc_en}, 3'b000, "sleep clocks");
        wake_low <= 1;
        wait_resume(60);
        wake_low <= 0;
        check(got, 1, "edge wake");
        check(n >= WARM, 1, "warm-up wait");
        sleep_cmd();
        repeat (10) @(posedge sys_clk);
        rst_low <= 1;
        repeat (8) @(posedge sys_clk);
        check(chip_reset, 1, "pin reset");
        rst_low <= 0;
        repeat (8) @(posedge sys_clk);
        check(osc_en, 1, "osc after reset");
        apb(0, A_SCR, 0);
        check(rd, `RST_SCR, "scr after reset");
        wdt <= 1;
        repeat (3) @(posedge sys_clk);
        check(chip_reset, 1, "watchdog reset");
        wdt <= 0;
        repeat (8) @(posedge sys_clk);
        $display("sleep test done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
endmodule : tb_top
